// file: bench/slc_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
// far switch on one serial link: counts symbols into tokens and answers greetings
module slc_remote_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sym_strobe_in,
	input wire logic [1:0] sym_kind_in,
	input wire logic wide_in,
	input wire logic [3:0] delay_in,
	input wire logic greet_cmd_in,
	output logic credit_out,
	output logic greeting_out,
	output logic [7:0] tok_count_out
);
	logic [2:0] syms;
	logic [3:0] wait_cnt;
	logic pend;

	// a slow delay_in shows that the block tolerates a late credit reply
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			syms <= 3'h0;
			wait_cnt <= 4'h0;
			pend <= 1'b0;
			credit_out <= 1'b0;
			greeting_out <= 1'b0;
			tok_count_out <= 8'h00;
		end else begin
			credit_out <= 1'b0;
			greeting_out <= greet_cmd_in;
			if (pend) begin
				if (wait_cnt == 4'h0) begin
					credit_out <= 1'b1;
					pend <= 1'b0;
				end else begin
					wait_cnt <= wait_cnt - 4'h1;
				end
			end
			// token boundary assumes the stream starts aligned after reset
			if (sym_strobe_in) begin
				if (syms == (wide_in ? 3'h1 : 3'h3)) begin
					syms <= 3'h0;
					tok_count_out <= tok_count_out + 8'h01;
					if (sym_kind_in == slc_pkg::KIND_GREET) begin
						pend <= 1'b1;
						wait_cnt <= delay_in;
					end
				end else begin
					syms <= syms + 3'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/tb_switch_link_config_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_switch_link_config_status;
	logic clk, rst, reg_wr, reg_rd, m_cred, m_greet, greet_cmd, irq;
	logic [7:0] addr, m_toks, pl_valid, st_valid, pass, st_en, st_fwd, st_route, en_exp;
	logic [31:0] wdata, rdata, seed, got;
	slc_pkg::slc_pl_stat_s [7:0] pl_stat;
	logic [15:0] pl_net;
	logic [8:0] xl_en, xl_wide, xl_rxrst, xl_err, xl_txv, xl_ready, xl_strb, xl_cred_tb;
	logic [17:0] xl_kind;
	logic [39:0] st_ce, ce_exp;
	int bad_count, num_checks, cyc, t0, t1;

	slc_link_cfg dut (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata),
		.PL_STAT_IN(pl_stat), .PL_FLIT_VALID_IN(pl_valid), .PL_FLIT_PASS_OUT(pass),
		.PL_NETWORK_OUT(pl_net), .XL_ENABLE_OUT(xl_en), .XL_WIDE_OUT(xl_wide),
		.XL_RX_RESET_OUT(xl_rxrst), .XL_RX_ERR_IN(xl_err),
		.XL_RX_CREDIT_IN(xl_cred_tb | {8'h00, m_cred}),
		.XL_RX_GREETING_IN({8'h00, m_greet}), .XL_TX_VALID_IN(xl_txv),
		.XL_TX_READY_OUT(xl_ready), .XL_SYM_STROBE_OUT(xl_strb), .XL_SYM_KIND_OUT(xl_kind),
		.ST_PKT_VALID_IN(st_valid), .ST_ENABLE_OUT(st_en), .ST_CHANEND_OUT(st_ce),
		.ST_FWD_OUT(st_fwd), .ST_ROUTE_OUT(st_route), .IRQ_OUT(irq));

	slc_remote_model far (.clk_in(clk), .rst_in(rst), .sym_strobe_in(xl_strb[0]),
		.sym_kind_in(xl_kind[1:0]), .wide_in(xl_wide[0]), .delay_in(4'h9),
		.greet_cmd_in(greet_cmd), .credit_out(m_cred), .greeting_out(m_greet),
		.tok_count_out(m_toks));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) cyc++;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected status word: reserved and read-only gaps read zero
	function automatic logic [31:0] pl_word(input slc_pkg::slc_pl_stat_s s, input logic [1:0] n);
		return {6'h00, s.target_type, s.dest_link, 10'h000, n, 1'b0, s.junk, s.dest_busy,
			s.src_busy};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// bounded wait for the next symbol on link 0
	task automatic wait_sym(input int lim, output int t);
		for (int k = 0; k < lim; k++) begin
			@(posedge clk);
			#1;
			if (xl_strb[0] === 1'b1) break;
		end
		t = cyc;
		chk("symbol arrival", 32'h1, 32'(xl_strb[0]));
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		seed = 32'h16;
		pl_stat = '0;
		pl_valid = 8'h00;
		st_valid = 8'h00;
		xl_err = 9'h000;
		xl_txv = 9'h000;
		xl_cred_tb = 9'h000;
		greet_cmd = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// processor links: random status, network written over random noise
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			pl_stat[i] <= seed[12:0];
			pl_valid <= seed[20:13];
			rd(slc_pkg::PL_BASE + 8'(i), got);
			chk("proc word reset", pl_word(pl_stat[i], 2'h0), got);
			wr(slc_pkg::PL_BASE + 8'(i), ~seed);
			rd(slc_pkg::PL_BASE + 8'(i), got);
			chk("proc word", pl_word(pl_stat[i], ~seed[5:4]), got);
			chk("network out", {30'h0, ~seed[5:4]}, 32'(pl_net[2*i +: 2]));
			chk("flit pass", 32'(pl_valid[i] & ~pl_stat[i].junk), 32'(pass[i]));
		end
		// external link 0: gaps 3 and 5, data waiting before any credit
		rd(slc_pkg::XL_BASE, got);
		chk("link word reset", 32'h0, got);
		xl_txv <= 9'h001;
		wr(slc_pkg::XL_BASE, 32'hB800_1805);
		rd(slc_pkg::XL_BASE, got);
		chk("link word", 32'h8000_1805, got);
		chk("link enable", 32'h1, 32'(xl_en));
		// no credit yet: not a single symbol may leave for thirty cycles
		for (int k = 0; k < 30; k++) begin
			@(posedge clk);
			#1;
			chk("strobe without credit", 32'h0, 32'(xl_strb[0]));
		end
		wr(slc_pkg::XL_BASE, 32'h8100_1805);
		wait_sym(30, t0);
		chk("greeting kind", 32'(slc_pkg::KIND_GREET), 32'(xl_kind[1:0]));
		wait_sym(30, t1);
		chk("symbol spacing", 32'h5, 32'(t1 - t0));
		wait_sym(30, t0);
		wait_sym(30, t0);
		wait_sym(80, t0);
		chk("data kind", 32'(slc_pkg::KIND_DATA), 32'(xl_kind[1:0]));
		for (int k = 0; k < 3; k++) wait_sym(30, t1);
		chk("token consumed", 32'h1, 32'(xl_ready[0]));
		wait_sym(40, t0);
		chk("token spacing", 32'h7, 32'(t0 - t1));
		for (int k = 0; k < 3; k++) wait_sym(30, t1);
		@(posedge clk);
		xl_txv <= 9'h000;
		rd(slc_pkg::XL_BASE, got);
		chk("credit held", 32'h8200_1805, got);
		@(posedge clk);
		greet_cmd <= 1'b1;
		@(posedge clk);
		greet_cmd <= 1'b0;
		wait_sym(40, t0);
		chk("credit kind", 32'(slc_pkg::KIND_CREDIT), 32'(xl_kind[1:0]));
		repeat (20) @(posedge clk);
		rd(slc_pkg::XL_BASE, got);
		chk("credit issued", 32'h8600_1805, got);
		chk("tokens seen", 32'h4, 32'(m_toks));
		// five-wire greeting: two symbols per token, remote replies with credit
		wr(slc_pkg::XL_BASE, 32'hC100_1805);
		chk("wide out", 32'h1, 32'(xl_wide[0]));
		wait_sym(30, t0);
		chk("wide greeting kind", 32'(slc_pkg::KIND_GREET), 32'(xl_kind[1:0]));
		wait_sym(30, t1);
		repeat (20) @(posedge clk);
		chk("tokens seen wide", 32'h5, 32'(m_toks));
		rd(slc_pkg::XL_BASE, got);
		chk("wide link word", 32'hC600_1805, got);
		// error on link 1, interrupt masked, unmasked, cleared
		@(posedge clk);
		xl_err <= 9'h002;
		@(posedge clk);
		xl_err <= 9'h000;
		rd(slc_pkg::XL_BASE + 8'h01, got);
		chk("error flag", 32'h0800_0000, got);
		chk("irq masked", 32'h0, 32'(irq));
		wr(slc_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
		@(posedge clk);
		#1;
		chk("irq raised", 32'h1, 32'(irq));
		rd(slc_pkg::IRQ_STAT_ADDR, got);
		chk("irq status", 32'h0001_0002, got);
		wr(slc_pkg::IRQ_STAT_ADDR, 32'h0000_0002);
		@(posedge clk);
		#1;
		chk("irq cleared", 32'h0, 32'(irq));
		wr(slc_pkg::XL_BASE + 8'h01, 32'h0080_0000);
		chk("receiver reset", 32'h002, 32'(xl_rxrst));
		rd(slc_pkg::XL_BASE + 8'h01, got);
		chk("after rx reset", 32'h0, got);
		rd(8'h30, got);
		chk("unmapped read", 32'h0, got);
		// last external link: enable, then a credit pulse from its remote end
		wr(slc_pkg::XL_BASE + 8'h08, 32'h8000_0000);
		chk("link 8 enable", 32'h101, 32'(xl_en));
		xl_cred_tb <= 9'h100;
		@(posedge clk);
		xl_cred_tb <= 9'h000;
		rd(slc_pkg::XL_BASE + 8'h08, got);
		chk("link 8 credit", 32'h8200_0000, got);
		// static registers in letter order C,D,A,B,G,H,E,F
		en_exp = 8'h00;
		ce_exp = 40'h0;
		for (int j = 0; j < 8; j++) begin
			wr(slc_pkg::ST_BASE + 8'(j), {j[0], 26'h3FF_FFFF, 5'(j * 3 + 1)});
			rd(slc_pkg::ST_BASE + 8'(j), got);
			chk("static word", {j[0], 26'h0, 5'(j * 3 + 1)}, got);
			en_exp[j ^ 2] = j[0];
			ce_exp[5 * (j ^ 2) +: 5] = 5'(j * 3 + 1);
		end
		seed = lfsr(seed);
		st_valid <= seed[7:0] | 8'h81;
		@(posedge clk);
		#1;
		chk("static enables", 32'(en_exp), 32'(st_en));
		chk("static chanends", ce_exp[31:0], st_ce[31:0]);
		chk("static chanends hi", 32'(ce_exp[39:32]), 32'(st_ce[39:32]));
		chk("forwarded", 32'(st_valid & en_exp), 32'(st_fwd));
		chk("routed", 32'(st_valid & ~en_exp), 32'(st_route));
		print_verdict();
	end
endmodule
`default_nettype wire

// file: verilog/slc_link_cfg.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module slc_link_cfg (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [31:0] REG_RDATA_OUT,
	input wire slc_pkg::slc_pl_stat_s [slc_pkg::N_PL-1:0] PL_STAT_IN,
	input wire logic [slc_pkg::N_PL-1:0] PL_FLIT_VALID_IN,
	output logic [slc_pkg::N_PL-1:0] PL_FLIT_PASS_OUT,
	output logic [2*slc_pkg::N_PL-1:0] PL_NETWORK_OUT,
	output logic [slc_pkg::N_XL-1:0] XL_ENABLE_OUT,
	output logic [slc_pkg::N_XL-1:0] XL_WIDE_OUT,
	output logic [slc_pkg::N_XL-1:0] XL_RX_RESET_OUT,
	input wire logic [slc_pkg::N_XL-1:0] XL_RX_ERR_IN,
	input wire logic [slc_pkg::N_XL-1:0] XL_RX_CREDIT_IN,
	input wire logic [slc_pkg::N_XL-1:0] XL_RX_GREETING_IN,
	input wire logic [slc_pkg::N_XL-1:0] XL_TX_VALID_IN,
	output logic [slc_pkg::N_XL-1:0] XL_TX_READY_OUT,
	output logic [slc_pkg::N_XL-1:0] XL_SYM_STROBE_OUT,
	output logic [2*slc_pkg::N_XL-1:0] XL_SYM_KIND_OUT,
	input wire logic [slc_pkg::N_ST-1:0] ST_PKT_VALID_IN,
	output logic [slc_pkg::N_ST-1:0] ST_ENABLE_OUT,
	output logic [5*slc_pkg::N_ST-1:0] ST_CHANEND_OUT,
	output logic [slc_pkg::N_ST-1:0] ST_FWD_OUT,
	output logic [slc_pkg::N_ST-1:0] ST_ROUTE_OUT,
	output logic IRQ_OUT
);
	slc_pkg::slc_regs_s s;
	slc_pkg::slc_regs_s n;
	logic [slc_pkg::N_XL-1:0] xl_credit;
	logic [slc_pkg::N_XL-1:0] xl_issued;
	logic [31:0] wclr;
	logic [31:0] evt;

	// register writes, command pulses, sticky flags and the read pipeline
	always_comb begin
		n = s;
		n.xl_greeting_token = '0;
		n.xl_rx_rst = '0;
		n.rdata = 32'h0000_0000;
		n.xl_credit_q = xl_credit;
		wclr = 32'h0000_0000;
		evt = 32'h0000_0000;
		if (REG_WR_IN) begin
			for (int i = 0; i < slc_pkg::N_PL; i++) begin
				if (REG_ADDR_IN == slc_pkg::PL_BASE + 8'(i)) begin
					n.pl_net[i] = REG_WDATA_IN[slc_pkg::PL_NET_LSB +: 2];
				end
			end
			for (int i = 0; i < slc_pkg::N_XL; i++) begin
				if (REG_ADDR_IN == slc_pkg::XL_BASE + 8'(i)) begin
					n.xl_cfg[i].en = REG_WDATA_IN[slc_pkg::XL_EN_BIT];
					n.xl_cfg[i].wide = REG_WDATA_IN[slc_pkg::XL_WIDE_BIT];
					n.xl_cfg[i].sym_gap = REG_WDATA_IN[slc_pkg::XL_SGAP_LSB +: 11];
					n.xl_cfg[i].tok_gap = REG_WDATA_IN[slc_pkg::XL_TGAP_LSB +: 11];
					n.xl_greeting_token[i] = REG_WDATA_IN[slc_pkg::XL_GREETING_TOKEN_BIT];
					n.xl_rx_rst[i] = REG_WDATA_IN[slc_pkg::XL_RXRST_BIT];
				end
			end
			for (int i = 0; i < slc_pkg::N_ST; i++) begin
				if (REG_ADDR_IN == slc_pkg::ST_BASE + 8'(i)) begin
					n.st_en[i] = REG_WDATA_IN[slc_pkg::ST_EN_BIT];
					n.st_ce[i] = REG_WDATA_IN[slc_pkg::ST_CE_LSB +: 5];
				end
			end
			if (REG_ADDR_IN == slc_pkg::IRQ_STAT_ADDR) begin
				wclr = REG_WDATA_IN;
			end
			if (REG_ADDR_IN == slc_pkg::IRQ_MASK_ADDR) begin
				n.irq_mask = REG_WDATA_IN;
			end
		end
		// error flag: a receiver reset clears it, a new error in that cycle wins
		n.xl_err = (s.xl_err & ~n.xl_rx_rst) | XL_RX_ERR_IN;
		evt[slc_pkg::IRQ_ERR_LSB +: slc_pkg::N_XL] = XL_RX_ERR_IN;
		evt[slc_pkg::IRQ_CREDIT_LSB +: slc_pkg::N_XL] = xl_credit & ~s.xl_credit_q;
		n.irq_stat = (s.irq_stat & ~wclr) | evt;
		// read data is registered so it stands exactly one cycle after the strobe
		if (REG_RD_IN) begin
			for (int i = 0; i < slc_pkg::N_PL; i++) begin
				if (REG_ADDR_IN == slc_pkg::PL_BASE + 8'(i)) begin
					n.rdata[slc_pkg::PL_TGT_LSB +: 2] = PL_STAT_IN[i].target_type;
					n.rdata[slc_pkg::PL_DEST_LSB +: 8] = PL_STAT_IN[i].dest_link;
					n.rdata[slc_pkg::PL_NET_LSB +: 2] = s.pl_net[i];
					n.rdata[slc_pkg::PL_JUNK_BIT] = PL_STAT_IN[i].junk;
					n.rdata[slc_pkg::PL_DBUSY_BIT] = PL_STAT_IN[i].dest_busy;
					n.rdata[slc_pkg::PL_SBUSY_BIT] = PL_STAT_IN[i].src_busy;
				end
			end
			for (int i = 0; i < slc_pkg::N_XL; i++) begin
				if (REG_ADDR_IN == slc_pkg::XL_BASE + 8'(i)) begin
					n.rdata[slc_pkg::XL_EN_BIT] = s.xl_cfg[i].en;
					n.rdata[slc_pkg::XL_WIDE_BIT] = s.xl_cfg[i].wide;
					n.rdata[slc_pkg::XL_ERR_BIT] = s.xl_err[i];
					n.rdata[slc_pkg::XL_ISSUED_BIT] = xl_issued[i];
					n.rdata[slc_pkg::XL_CREDIT_BIT] = xl_credit[i];
					n.rdata[slc_pkg::XL_SGAP_LSB +: 11] = s.xl_cfg[i].sym_gap;
					n.rdata[slc_pkg::XL_TGAP_LSB +: 11] = s.xl_cfg[i].tok_gap;
				end
			end
			for (int i = 0; i < slc_pkg::N_ST; i++) begin
				if (REG_ADDR_IN == slc_pkg::ST_BASE + 8'(i)) begin
					n.rdata[slc_pkg::ST_EN_BIT] = s.st_en[i];
					n.rdata[slc_pkg::ST_CE_LSB +: 5] = s.st_ce[i];
				end
			end
			if (REG_ADDR_IN == slc_pkg::IRQ_STAT_ADDR) begin
				n.rdata = s.irq_stat;
			end
			if (REG_ADDR_IN == slc_pkg::IRQ_MASK_ADDR) begin
				n.rdata = s.irq_mask;
			end
		end
	end

	// all control state from one register bank
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s <= '0;
			for (int i = 0; i < slc_pkg::N_PL; i++) begin
				s.pl_net[i] <= slc_pkg::PL_NET_RST;
			end
			for (int i = 0; i < slc_pkg::N_XL; i++) begin
				s.xl_cfg[i].en <= slc_pkg::XL_EN_RST;
				s.xl_cfg[i].wide <= slc_pkg::XL_WIDE_RST;
				s.xl_cfg[i].sym_gap <= slc_pkg::XL_GAP_RST;
				s.xl_cfg[i].tok_gap <= slc_pkg::XL_GAP_RST;
			end
			for (int i = 0; i < slc_pkg::N_ST; i++) begin
				s.st_en[i] <= slc_pkg::ST_EN_RST;
				s.st_ce[i] <= slc_pkg::ST_CE_RST;
			end
		end else begin
			s <= n;
		end
	end

	assign REG_RDATA_OUT = s.rdata;
	// level interrupt, high while any unmasked sticky bit is set
	assign IRQ_OUT = |(s.irq_stat & s.irq_mask);

	// processor-side links: junk packets never leave the block
	genvar g;
	generate
		for (g = 0; g < slc_pkg::N_PL; g++) begin : g_pl
			assign PL_FLIT_PASS_OUT[g] = PL_FLIT_VALID_IN[g] & ~PL_STAT_IN[g].junk;
			assign PL_NETWORK_OUT[2*g +: 2] = s.pl_net[g];
		end
	endgenerate

	// external links: one pacer each, disabled links start no token
	generate
		for (g = 0; g < slc_pkg::N_XL; g++) begin : g_xl
			slc_pkg::slc_kind_e kind;
			slc_tx_pacer u_pacer (
				.clk_in(CLK_SYS_IN),
				.rst_in(RST_IN),
				.enable_in(s.xl_cfg[g].en),
				.wide_in(s.xl_cfg[g].wide),
				.sym_gap_in(s.xl_cfg[g].sym_gap),
				.tok_gap_in(s.xl_cfg[g].tok_gap),
				.greeting_token_in(s.xl_greeting_token[g]),
				.rx_credit_in(XL_RX_CREDIT_IN[g]),
				.rx_greeting_in(XL_RX_GREETING_IN[g]),
				.tx_valid_in(XL_TX_VALID_IN[g]),
				.tx_ready_out(XL_TX_READY_OUT[g]),
				.sym_strobe_out(XL_SYM_STROBE_OUT[g]),
				.sym_kind_out(kind),
				.credit_out(xl_credit[g]),
				.issued_out(xl_issued[g])
			);
			assign XL_SYM_KIND_OUT[2*g +: 2] = kind;
			assign XL_ENABLE_OUT[g] = s.xl_cfg[g].en;
			assign XL_WIDE_OUT[g] = s.xl_cfg[g].wide;
			assign XL_RX_RESET_OUT[g] = s.xl_rx_rst[g];
		end
	endgenerate

	// static links: outputs indexed by link letter, registers by address order
	generate
		for (g = 0; g < slc_pkg::N_ST; g++) begin : g_st
			localparam logic [2:0] LNK = slc_pkg::st_link(3'(g));
			assign ST_ENABLE_OUT[LNK] = s.st_en[g];
			assign ST_CHANEND_OUT[5*LNK +: 5] = s.st_ce[g];
		end
	endgenerate
	// an enabled static link bypasses the router for every packet
	assign ST_FWD_OUT = ST_PKT_VALID_IN & ST_ENABLE_OUT;
	assign ST_ROUTE_OUT = ST_PKT_VALID_IN & ~ST_ENABLE_OUT;

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);

	property p_tgt_read;
		REG_RD_IN && REG_ADDR_IN == slc_pkg::PL_BASE
			|=> REG_RDATA_OUT[25:24] == $past(PL_STAT_IN[0].target_type);
	endproperty
	a_tgt_read: assert property (p_tgt_read) else $error("target type misread");
	property p_dest_read;
		REG_RD_IN && REG_ADDR_IN == slc_pkg::PL_BASE + 8'h03
			|=> REG_RDATA_OUT[23:16] == $past(PL_STAT_IN[3].dest_link);
	endproperty
	a_dest_read: assert property (p_dest_read) else $error("destination misread");
	property p_net_write;
		REG_WR_IN && REG_ADDR_IN == slc_pkg::PL_BASE + 8'h07
			|=> PL_NETWORK_OUT[15:14] == $past(REG_WDATA_IN[5:4]);
	endproperty
	a_net_write: assert property (p_net_write) else $error("network not stored");
	property p_junk;
		PL_STAT_IN[1].junk |-> !PL_FLIT_PASS_OUT[1];
	endproperty
	a_junk: assert property (p_junk) else $error("junk packet passed");
	property p_enable;
		REG_WR_IN && REG_ADDR_IN == slc_pkg::XL_BASE + 8'h08
			|=> XL_ENABLE_OUT[8] == $past(REG_WDATA_IN[31]);
	endproperty
	a_enable: assert property (p_enable) else $error("link enable not stored");
	property p_rxrst;
		REG_WR_IN && REG_ADDR_IN == slc_pkg::XL_BASE + 8'h01 && REG_WDATA_IN[23]
			##1 !(REG_WR_IN && REG_ADDR_IN == slc_pkg::XL_BASE + 8'h01)
			|-> XL_RX_RESET_OUT[1] ##1 !XL_RX_RESET_OUT[1];
	endproperty
	a_rxrst: assert property (p_rxrst) else $error("receiver reset not one pulse");
	property p_err_sticky;
		XL_RX_ERR_IN[1] |=> s.xl_err[1] && s.irq_stat[1];
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error not flagged");
	property p_st_map;
		REG_WR_IN && REG_ADDR_IN == slc_pkg::ST_BASE
			|=> ST_ENABLE_OUT[2] == $past(REG_WDATA_IN[31]) &&
			ST_CHANEND_OUT[14:10] == $past(REG_WDATA_IN[4:0]);
	endproperty
	a_st_map: assert property (p_st_map) else $error("static map wrong");
	property p_wo_zero;
		REG_RD_IN && REG_ADDR_IN == slc_pkg::XL_BASE + 8'h01
			|=> REG_RDATA_OUT[29:28] == 2'h0 && REG_RDATA_OUT[24:22] == 3'h0;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("reserved bits not zero");
	property p_cov_greeting_token;
		REG_WR_IN && REG_ADDR_IN == slc_pkg::XL_BASE && REG_WDATA_IN[24];
	endproperty
	c_cov_greeting_token: cover property (p_cov_greeting_token);
	property p_cov_fwd;
		|ST_FWD_OUT;
	endproperty
	c_cov_fwd: cover property (p_cov_fwd);
	property p_cov_irq;
		!IRQ_OUT ##1 IRQ_OUT;
	endproperty
	c_cov_irq: cover property (p_cov_irq);
endmodule
`default_nettype wire

// file: verilog/slc_pkg.sv
package slc_pkg;
	localparam int N_PL = 8;
	localparam int N_XL = 9;
	localparam int N_ST = 8;
	// register indices, the address port carries the index directly
	localparam logic [7:0] PL_BASE = 8'h40;
	localparam logic [7:0] XL_BASE = 8'h80;
	localparam logic [7:0] ST_BASE = 8'hA0;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'hC0;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'hC1;
	// field positions
	localparam int PL_TGT_LSB = 24;
	localparam int PL_DEST_LSB = 16;
	localparam int PL_NET_LSB = 4;
	localparam int PL_JUNK_BIT = 2;
	localparam int PL_DBUSY_BIT = 1;
	localparam int PL_SBUSY_BIT = 0;
	localparam int XL_EN_BIT = 31;
	localparam int XL_WIDE_BIT = 30;
	localparam int XL_ERR_BIT = 27;
	localparam int XL_ISSUED_BIT = 26;
	localparam int XL_CREDIT_BIT = 25;
	localparam int XL_GREETING_TOKEN_BIT = 24;
	localparam int XL_RXRST_BIT = 23;
	localparam int XL_SGAP_LSB = 11;
	localparam int XL_TGAP_LSB = 0;
	localparam int ST_EN_BIT = 31;
	localparam int ST_CE_LSB = 0;
	localparam int IRQ_ERR_LSB = 0;
	localparam int IRQ_CREDIT_LSB = 16;
	// reset values
	localparam logic [1:0] PL_NET_RST = 2'h0;
	localparam logic XL_EN_RST = 1'b0;
	localparam logic XL_WIDE_RST = 1'b0;
	localparam logic [10:0] XL_GAP_RST = 11'h000;
	localparam logic ST_EN_RST = 1'b0;
	localparam logic [4:0] ST_CE_RST = 5'h00;
	// symbols per token minus one, by wire mode
	localparam logic [2:0] SYMS_2W_M1 = 3'h3;
	localparam logic [2:0] SYMS_5W_M1 = 3'h1;

	typedef struct packed {
		logic [1:0] target_type;
		logic [7:0] dest_link;
		logic junk;
		logic dest_busy;
		logic src_busy;
	} slc_pl_stat_s;

	typedef struct packed {
		logic en;
		logic wide;
		logic [10:0] sym_gap;
		logic [10:0] tok_gap;
	} slc_xl_cfg_s;

	typedef enum logic [1:0] {KIND_DATA = 2'b00, KIND_GREET = 2'b01, KIND_CREDIT = 2'b10}
		slc_kind_e;
	typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_SYM = 2'b01, PS_GAP = 2'b10} slc_pstate_e;

	typedef struct packed {
		slc_pstate_e st;
		slc_kind_e kind;
		logic [10:0] cnt;
		logic [2:0] left;
		logic credit;
		logic issued;
		logic greet_pend;
		logic credit_pend;
	} slc_pacer_s;

	typedef struct packed {
		logic [N_PL-1:0][1:0] pl_net;
		slc_xl_cfg_s [N_XL-1:0] xl_cfg;
		logic [N_XL-1:0] xl_err;
		logic [N_XL-1:0] xl_credit_q;
		logic [N_XL-1:0] xl_greeting_token;
		logic [N_XL-1:0] xl_rx_rst;
		logic [N_ST-1:0] st_en;
		logic [N_ST-1:0][4:0] st_ce;
		logic [31:0] irq_stat;
		logic [31:0] irq_mask;
		logic [31:0] rdata;
	} slc_regs_s;

	// static register index to link letter number (A=0): C,D,A,B,G,H,E,F
	function automatic logic [2:0] st_link(input logic [2:0] idx);
		return idx ^ 3'h2;
	endfunction
endpackage

// file: verilog/slc_tx_pacer.sv
`timescale 1ns/1ps
`default_nettype none
module slc_tx_pacer (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic wide_in,
	input wire logic [10:0] sym_gap_in,
	input wire logic [10:0] tok_gap_in,
	input wire logic greeting_token_in,
	input wire logic rx_credit_in,
	input wire logic rx_greeting_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic sym_strobe_out,
	output slc_pkg::slc_kind_e sym_kind_out,
	output logic credit_out,
	output logic issued_out
);
	slc_pkg::slc_pacer_s s;
	slc_pkg::slc_pacer_s n;

	// token scheduler: greeting first, then credit reply, then data
	always_comb begin
		n = s;
		tx_ready_out = 1'b0;
		case (s.st)
			slc_pkg::PS_IDLE: begin
				if (s.cnt != 11'h000) begin
					n.cnt = s.cnt - 11'h001;
				end else if (enable_in && (s.greet_pend || s.credit_pend ||
						(tx_valid_in && s.credit))) begin
					n.st = slc_pkg::PS_SYM;
					n.left = wide_in ? slc_pkg::SYMS_5W_M1 : slc_pkg::SYMS_2W_M1;
					if (s.greet_pend) begin
						n.kind = slc_pkg::KIND_GREET;
						n.greet_pend = 1'b0;
					end else if (s.credit_pend) begin
						n.kind = slc_pkg::KIND_CREDIT;
						n.credit_pend = 1'b0;
					end else begin
						n.kind = slc_pkg::KIND_DATA;
					end
				end
			end
			slc_pkg::PS_SYM: begin
				if (s.left == 3'h0) begin
					n.st = slc_pkg::PS_IDLE;
					n.cnt = tok_gap_in;
					tx_ready_out = (s.kind == slc_pkg::KIND_DATA);
					if (s.kind == slc_pkg::KIND_CREDIT) begin
						n.issued = 1'b1;
					end
				end else begin
					n.st = slc_pkg::PS_GAP;
					n.cnt = sym_gap_in;
					n.left = s.left - 3'h1;
				end
			end
			slc_pkg::PS_GAP: begin
				if (s.cnt != 11'h000) begin
					n.cnt = s.cnt - 11'h001;
				end else begin
					n.st = slc_pkg::PS_SYM;
				end
			end
			default: begin
				n.st = slc_pkg::PS_IDLE;
			end
		endcase
		// events after the scheduler so a new request is never cleared away
		if (greeting_token_in) begin
			n.credit = 1'b0;
			n.greet_pend = 1'b1;
		end
		if (rx_credit_in) begin
			n.credit = 1'b1; // set wins over the greeting_token clear
		end
		if (rx_greeting_in) begin
			n.credit_pend = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign sym_strobe_out = (s.st == slc_pkg::PS_SYM);
	assign sym_kind_out = s.kind;
	assign credit_out = s.credit;
	assign issued_out = s.issued;

	// helper: idle cycles since the last symbol and whether it closed a token
	logic [11:0] idle_run;
	logic ended_tok;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_run <= 12'hFFF;
			ended_tok <= 1'b1;
		end else if (sym_strobe_out) begin
			idle_run <= 12'h000;
			ended_tok <= (s.left == 3'h0);
		end else if (idle_run != 12'hFFF) begin
			idle_run <= idle_run + 12'h001;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_data_credit;
		(s.st == slc_pkg::PS_IDLE && n.st == slc_pkg::PS_SYM && n.kind == slc_pkg::KIND_DATA)
			|-> s.credit;
	endproperty
	a_data_credit: assert property (p_data_credit) else $error("data token without credit");
	property p_greeting_token_clear;
		greeting_token_in && !rx_credit_in |=> !credit_out ##1 1'b1;
	endproperty
	a_greeting_token_clear: assert property (p_greeting_token_clear) else $error("greeting_token left credit set");
	property p_tok_gap;
		sym_strobe_out && ended_tok |-> idle_run > {1'b0, tok_gap_in};
	endproperty
	a_tok_gap: assert property (p_tok_gap) else $error("token gap too short");
	property p_sym_gap;
		sym_strobe_out && !ended_tok |-> idle_run > {1'b0, sym_gap_in};
	endproperty
	a_sym_gap: assert property (p_sym_gap) else $error("symbol gap too short");
	property p_greet_reply;
		rx_greeting_in && enable_in && s.st == slc_pkg::PS_IDLE && s.cnt == 11'h000 &&
			!s.greet_pend |=> s.credit_pend || sym_kind_out == slc_pkg::KIND_CREDIT;
	endproperty
	a_greet_reply: assert property (p_greet_reply) else $error("greeting not answered");
	property p_cov_greet;
		sym_strobe_out && sym_kind_out == slc_pkg::KIND_GREET;
	endproperty
	c_cov_greet: cover property (p_cov_greet);
endmodule
`default_nettype wire
